// *** logic/mac_unit_pkg.sv ***
// Constants, field layout and operation codes for the multiply-to-accumulator datapath.
// Assumes a 24-bit instruction word and 16-bit working registers.
`default_nettype none

package mac_unit_pkg;

  // Widths
  localparam int WORD_W = 16;
  localparam int ACC_W = 40;
  localparam int INSTR_W = 24;

  // Instruction field positions
  localparam int F_OPC_LSB = 19;
  localparam int F_SQR_LSB = 18;
  localparam int F_M_LSB = 16;
  localparam int F_ACC_BIT = 15;
  localparam int F_SUB_BIT = 14;
  localparam int F_X_LSB = 12;
  localparam int F_Y_LSB = 10;
  localparam int F_I_LSB = 6;
  localparam int F_J_LSB = 2;
  localparam int F_AA_LSB = 0;

  // Opcode patterns
  localparam logic [4:0] OPC_MAC = 5'h18;
  localparam logic [5:0] OPC_SQR = 6'h3c;
  localparam logic [2:0] M_PFST = 3'h7;
  localparam logic [2:0] M_UNUSED = 3'h3;
  localparam logic [1:0] AA_MULT = 2'h3;
  localparam logic [1:0] AA_SQR = 2'h1;

  // Write-back target codes
  localparam logic [1:0] WB_REG = 2'h0;
  localparam logic [1:0] WB_MEM = 2'h1;
  localparam logic [WORD_W-1:0] WB_STEP = 16'h0002;

  // Prefetch field codes
  localparam logic [3:0] PF_NONE = 4'h4;
  localparam logic [3:0] PF_OFFSET = 4'hc;
  localparam logic [3:0] PTR_BASE_NUM = 4'h8;

  // Rounding and overflow
  localparam logic [ACC_W-1:0] ROUND_ADD = 40'h00_0000_8000;
  localparam int RND_LSB = 16;
  localparam int GUARD_LSB = 31;

  // Core control bit choosing integer mode
  localparam int IF_BIT = 0;

  // Reset values
  localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MUL = 3'b001,
    OP_SQR = 3'b010,
    OP_NEG = 3'b011,
    OP_SUB = 3'b100,
    OP_PFST = 3'b101
  } op_t;

endpackage : mac_unit_pkg

`default_nettype wire

// *** logic/mac_multiplier.sv ***
// Signed 16x16 multiplier with fractional scaling and optional negation.
// Assumes operands are stable register values; purely combinational.
`default_nettype none

module mac_multiplier
  import mac_unit_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int AW = ACC_W
) (
  // Operands
  input wire logic [W-1:0] factor_a,
  input wire logic [W-1:0] factor_b,
  // Mode
  input wire logic int_mode,
  input wire logic negate,
  // Result
  output logic [AW-1:0] product
);

  logic signed [2*W-1:0] raw;
  logic [AW-1:0] ext;
  logic [AW-1:0] scaled;

  assign raw = $signed(factor_a) * $signed(factor_b);
  assign ext = {{(AW-2*W){raw[2*W-1]}}, raw};
  assign scaled = int_mode ? ext : {ext[AW-2:0], 1'b0};
  assign product = negate ? ('0 - scaled) : scaled;

endmodule : mac_multiplier

`default_nettype wire

// *** logic/dsp_mac_multiply_unit.sv ***
// Multiply-to-accumulator execution datapath with dual prefetch and write-back.
// Assumes register values and memory read data arrive in the instruction's cycle.
//
// Overview of operation
// - Plain multiply: signed product, sign-extended to 40 bits, replaces accumulator.
// - Three select bits pick one of six pairs from registers four to seven.
// - X prefetch reads via register 8 or 9, then steps it by signed amount.
// - Register-offset prefetch uses pointer 9 or 11 plus 12, unmodified.
// - Core control bit 0 selects integer or fractional multiplication.
// - Plain multiply decoded from 1100 0mmm A0xx ... with low bits 11.
// - Square variant squares one of registers four to seven into accumulator.
// - Negated multiply stores negative signed product, sign-extended, into accumulator.
// - Negated multiply updates only overflow flags, saturation flags untouched.
// - Multiply, square, multiply-subtract update overflow flags; only multiply-subtract sets saturation flags.
// - Multiply-subtract subtracts sign-extended product from the selected accumulator.
// - Multiply-subtract decoded from 1100 0mmm A1xx; low bits pick write-back.
// - Write-back stores other accumulator rounded to W13 or to memory at W13, +2.
// - Prefetch-and-store accumulator bit names the other accumulator written back.
// - A bit picks accumulator; x,y pick destinations; i,j pick prefetch operations.
// - Prefetch-and-store does no arithmetic and changes no flags.
`default_nettype none

module dsp_mac_multiply_unit
  import mac_unit_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction from the decoder
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [WORD_W-1:0] core_control_register,
  // Working register values before this instruction
  input wire logic [WORD_W-1:0] w4,
  input wire logic [WORD_W-1:0] w5,
  input wire logic [WORD_W-1:0] w6,
  input wire logic [WORD_W-1:0] w7,
  input wire logic [WORD_W-1:0] w8,
  input wire logic [WORD_W-1:0] w9,
  input wire logic [WORD_W-1:0] w10,
  input wire logic [WORD_W-1:0] w11,
  input wire logic [WORD_W-1:0] w12,
  input wire logic [WORD_W-1:0] w13,
  // Data memory reads, index 0 X space, index 1 Y space
  output logic [1:0] mem_rd_en,
  output logic [1:0][WORD_W-1:0] mem_rd_addr,
  input wire logic [1:0][WORD_W-1:0] mem_rd_data,
  // Prefetch destination writes, destination 0..3 means W4..W7
  output logic [1:0] pf_we_q,
  output logic [1:0][1:0] pf_dest_q,
  output logic [1:0][WORD_W-1:0] pf_data_q,
  // Pointer register writes
  output logic [1:0] ptr_we_q,
  output logic [1:0][3:0] ptr_num_q,
  output logic [1:0][WORD_W-1:0] ptr_data_q,
  // W13 write and accumulator store to memory
  output logic w13_we_q,
  output logic [WORD_W-1:0] w13_data_q,
  output logic mem_wr_en_q,
  output logic [WORD_W-1:0] mem_wr_addr_q,
  output logic [WORD_W-1:0] mem_wr_data_q,
  // Accumulators
  output logic [ACC_W-1:0] accumulator_a,
  output logic [ACC_W-1:0] accumulator_b,
  // Status flags, saturation cleared by software, bit 0 A, bit 1 B
  input wire logic [1:0] sat_clear,
  output logic acc_a_overflow_flag,
  output logic acc_b_overflow_flag,
  output logic either_acc_overflow_flag,
  output logic acc_a_saturation_flag,
  output logic acc_b_saturation_flag,
  output logic either_acc_saturation_flag
);

  op_t op;
  logic mac_grp;
  logic sqr_grp;
  logic [2:0] mfld;
  logic acc_sel;
  logic sub_bit;
  logic [1:0] aa;
  logic int_mode;

  assign mfld = instr[F_M_LSB+:3];
  assign acc_sel = instr[F_ACC_BIT];
  assign sub_bit = instr[F_SUB_BIT];
  assign aa = instr[F_AA_LSB+:2];
  assign mac_grp = instr[INSTR_W-1:F_OPC_LSB] == OPC_MAC;
  assign sqr_grp = instr[INSTR_W-1:F_SQR_LSB] == OPC_SQR;

  assign op = !instr_valid ? OP_NONE :
              (sqr_grp && !sub_bit && aa == AA_SQR) ? OP_SQR :
              !mac_grp ? OP_NONE :
              (mfld == M_PFST) ? (sub_bit ? OP_NONE : OP_PFST) :
              (mfld == M_UNUSED) ? OP_NONE :
              !sub_bit ? ((aa == AA_MULT) ? OP_MUL : OP_NONE) :
              (aa == AA_MULT) ? OP_NEG : OP_SUB;

  assign int_mode = core_control_register[IF_BIT];

  // Operand selection
  logic [WORD_W-1:0] dsp_reg [4];
  logic [1:0] first_idx;
  logic [1:0] second_idx;
  logic [WORD_W-1:0] first_factor_reg;
  logic [WORD_W-1:0] second_factor_reg;

  assign dsp_reg[0] = w4;
  assign dsp_reg[1] = w5;
  assign dsp_reg[2] = w6;
  assign dsp_reg[3] = w7;
  assign first_idx = (op == OP_SQR) ? mfld[1:0] :
                     mfld[2] ? (mfld[1] ? 2'h2 : 2'h1) : 2'h0;
  assign second_idx = (op == OP_SQR) ? mfld[1:0] :
                      mfld[2] ? ((mfld[1] | mfld[0]) ? 2'h3 : 2'h2) :
                      (mfld[1:0] + 2'h1);
  assign first_factor_reg = dsp_reg[first_idx];
  assign second_factor_reg = dsp_reg[second_idx];

  logic [ACC_W-1:0] product;

  mac_multiplier #(
    .W(WORD_W),
    .AW(ACC_W)
  ) u_mult (
    .factor_a(first_factor_reg),
    .factor_b(second_factor_reg),
    .int_mode(int_mode),
    .negate(op == OP_NEG),
    .product(product)
  );

  // Accumulator arithmetic
  logic [ACC_W-1:0] acc_q [2];
  logic [ACC_W-1:0] target;
  logic [ACC_W:0] diff;
  logic [ACC_W-1:0] result;
  logic is_arith;
  logic wide_ovf;
  logic guard_ovf;
  logic [1:0] hit;

  assign is_arith = op == OP_MUL || op == OP_SQR || op == OP_NEG || op == OP_SUB;
  assign target = acc_q[acc_sel];
  assign diff = {target[ACC_W-1], target} - {product[ACC_W-1], product};
  assign result = (op == OP_SUB) ? diff[ACC_W-1:0] : product;
  assign wide_ovf = (op == OP_SUB) && (diff[ACC_W] ^ diff[ACC_W-1]);
  assign guard_ovf = !((&result[ACC_W-1:GUARD_LSB]) || !(|result[ACC_W-1:GUARD_LSB]));
  assign hit = !is_arith ? 2'h0 : (acc_sel ? 2'h2 : 2'h1);

  // Flags
  logic [1:0] ov_q;
  logic [1:0] ov_d;
  logic [1:0] sat_q;
  logic [1:0] sat_d;
  logic [1:0] sat_set;

  assign ov_d = (ov_q & ~hit) | (hit & {2{guard_ovf}});
  assign sat_set = (op == OP_NEG) ? 2'h0 : (hit & {2{wide_ovf}});
  // Set wins over clear
  assign sat_d = (sat_q & ~sat_clear) | sat_set;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q[0] <= ACC_RST;
      acc_q[1] <= ACC_RST;
      ov_q <= 2'h0;
      sat_q <= 2'h0;
    end else begin
      acc_q[0] <= hit[0] ? result : acc_q[0];
      acc_q[1] <= hit[1] ? result : acc_q[1];
      ov_q <= ov_d;
      sat_q <= sat_d;
    end
  end

  assign accumulator_a = acc_q[0];
  assign accumulator_b = acc_q[1];
  assign acc_a_overflow_flag = ov_q[0];
  assign acc_b_overflow_flag = ov_q[1];
  assign either_acc_overflow_flag = |ov_q;
  assign acc_a_saturation_flag = sat_q[0];
  assign acc_b_saturation_flag = sat_q[1];
  assign either_acc_saturation_flag = |sat_q;

  // Prefetch channels
  logic [1:0][3:0] pf_fld;
  logic [1:0][1:0] pf_dst;
  logic [1:0] pf_go;
  logic [1:0] ptr_go;
  logic [1:0][3:0] ptr_num;
  logic [1:0][WORD_W-1:0] ptr_next;
  logic [WORD_W-1:0] ptr_lo [2];
  logic [WORD_W-1:0] ptr_hi [2];

  assign pf_fld = {instr[F_J_LSB+:4], instr[F_I_LSB+:4]};
  assign pf_dst = {instr[F_Y_LSB+:2], instr[F_X_LSB+:2]};
  assign ptr_lo[0] = w8;
  assign ptr_hi[0] = w9;
  assign ptr_lo[1] = w10;
  assign ptr_hi[1] = w11;

  for (genvar c = 0; c < 2; c++) begin : g_pf
    logic offset;
    logic [WORD_W-1:0] base;
    logic [WORD_W-1:0] step;
    assign offset = pf_fld[c] == PF_OFFSET;
    assign base = pf_fld[c][3] ? ptr_hi[c] : ptr_lo[c];
    assign step = {{(WORD_W-4){pf_fld[c][2]}}, pf_fld[c][2:0], 1'b0};
    assign pf_go[c] = op != OP_NONE && pf_fld[c] != PF_NONE;
    assign mem_rd_en[c] = pf_go[c];
    assign mem_rd_addr[c] = offset ? base + w12 : base;
    assign ptr_go[c] = pf_go[c] && !offset && pf_fld[c][2:0] != 3'h0;
    assign ptr_next[c] = base + step;
    assign ptr_num[c] = PTR_BASE_NUM | {2'h0, c == 1, pf_fld[c][3]};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pf_we_q <= 2'h0;
      pf_dest_q <= '0;
      pf_data_q <= '0;
      ptr_we_q <= 2'h0;
      ptr_num_q <= '0;
      ptr_data_q <= '0;
    end else begin
      pf_we_q <= pf_go;
      pf_dest_q <= pf_dst;
      pf_data_q <= mem_rd_data;
      ptr_we_q <= ptr_go;
      ptr_num_q <= ptr_num;
      ptr_data_q <= ptr_next;
    end
  end

  // Accumulator write-back
  logic [ACC_W-1:0] other_acc;
  logic [ACC_W-1:0] rounded_full;
  logic [WORD_W-1:0] rounded;
  logic wb_go;
  logic wb_mem;

  assign other_acc = acc_q[!acc_sel];
  assign rounded_full = other_acc + ROUND_ADD;
  assign rounded = rounded_full[RND_LSB+:WORD_W];
  assign wb_go = (op == OP_SUB || op == OP_PFST) && (aa == WB_REG || aa == WB_MEM);
  assign wb_mem = aa == WB_MEM;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w13_we_q <= 1'b0;
      w13_data_q <= WORD_RST;
      mem_wr_en_q <= 1'b0;
      mem_wr_addr_q <= WORD_RST;
      mem_wr_data_q <= WORD_RST;
    end else begin
      w13_we_q <= wb_go;
      w13_data_q <= wb_mem ? w13 + WB_STEP : rounded;
      mem_wr_en_q <= wb_go && wb_mem;
      mem_wr_addr_q <= w13;
      mem_wr_data_q <= rounded;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_MUL_REPLACE: assert property (
    op == OP_MUL && !acc_sel |=> accumulator_a == $past(product))
    else $error("plain multiply did not load accumulator A");

  AST_PAIR_SEL: assert property (
    op == OP_MUL && mfld == 3'h5 |-> first_factor_reg == w5 && second_factor_reg == w7)
    else $error("operand pair 5 by 7 not selected");

  AST_X_STEP: assert property (
    op != OP_NONE && pf_fld[0] == 4'h7
    |=> ptr_we_q[0] && ptr_num_q[0] == 4'h8 && ptr_data_q[0] == $past(w8) - 16'h0002)
    else $error("X pointer post-decrement by 2 wrong");

  AST_Y_OFFSET: assert property (
    op != OP_NONE && pf_fld[1] == PF_OFFSET
    |-> mem_rd_addr[1] == w11 + w12 ##1 pf_we_q[1] && !ptr_we_q[1])
    else $error("Y register-offset prefetch wrong");

  AST_NEG_SAT: assert property (
    op == OP_NEG && sat_clear == 2'h0 |=> $stable(sat_q))
    else $error("negated multiply touched saturation flags");

  AST_SUB_DIFF: assert property (
    op == OP_SUB && acc_sel |=> accumulator_b == $past(accumulator_b) - $past(product))
    else $error("multiply-subtract result wrong");

  AST_WB_MEM: assert property (
    op == OP_SUB && aa == WB_MEM
    |=> mem_wr_en_q && mem_wr_addr_q == $past(w13) && w13_data_q == $past(w13) + 16'h0002)
    else $error("write-back to memory wrong");

  AST_PFST_IDLE: assert property (
    op == OP_PFST |=> $stable(accumulator_a) && $stable(accumulator_b) && $stable(ov_q))
    else $error("prefetch-and-store changed accumulator state");

  COV_MUL_SUB: cover property (op == OP_MUL ##1 op == OP_SUB);
  COV_WB_MEM: cover property (op == OP_SUB && aa == WB_MEM);
  COV_DUAL_PF: cover property (op == OP_PFST && pf_go == 2'h3);

endmodule : dsp_mac_multiply_unit

`default_nettype wire

// *** verif/core_model.sv ***
// Behavioural register file W4..W13 and X/Y data memory beside the datapath.
// Assumes register and memory writes arrive as one-cycle enables; reads are combinational.
`default_nettype none

module core_model (
  // Clock
  input wire logic mclk,
  // Data memory
  input wire logic [1:0] mem_rd_en,
  input wire logic [1:0][15:0] mem_rd_addr,
  output logic [1:0][15:0] mem_rd_data,
  input wire logic mem_wr_en_q,
  input wire logic [15:0] mem_wr_addr_q,
  input wire logic [15:0] mem_wr_data_q,
  // Register writes
  input wire logic [1:0] pf_we_q,
  input wire logic [1:0][1:0] pf_dest_q,
  input wire logic [1:0][15:0] pf_data_q,
  input wire logic [1:0] ptr_we_q,
  input wire logic [1:0][3:0] ptr_num_q,
  input wire logic [1:0][15:0] ptr_data_q,
  input wire logic w13_we_q,
  input wire logic [15:0] w13_data_q,
  // Register contents
  output var logic [13:4][15:0] r
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [65536];
  logic [65535:0] stored = '0;
  logic [15:0] cyc = 16'h0000;

  // Unwritten words read back as a pattern of the address
  function automatic logic [15:0] peek(input logic [15:0] a);
    return stored[a] ? mem[a] : a ^ 16'hc3a5;
  endfunction : peek

  // Idle lanes change every cycle so stale data never passes for a fetch
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      mem_rd_data[k] = mem_rd_en[k] ? peek(mem_rd_addr[k]) : ~(mem_rd_addr[k] ^ cyc);
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 16'h0001;
    for (int k = 0; k < 2; k++) begin
      if (pf_we_q[k]) r[4 + pf_dest_q[k]] <= pf_data_q[k];
      if (ptr_we_q[k]) r[ptr_num_q[k]] <= ptr_data_q[k];
    end
    if (w13_we_q) r[13] <= w13_data_q;
    if (mem_wr_en_q) mem[mem_wr_addr_q] <= mem_wr_data_q;
    if (mem_wr_en_q) stored[mem_wr_addr_q] <= 1'b1;
  end
endmodule : core_model

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the multiply-to-accumulator datapath.
// Assumes core_model answers memory reads in the instruction's cycle.
`default_nettype none

module testbench
  import mac_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst;
  logic instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [WORD_W-1:0] ccr;
  logic [1:0] sat_clear;
  wire [1:0] mem_rd_en, pf_we_q, ptr_we_q;
  wire [1:0][WORD_W-1:0] mem_rd_addr, mem_rd_data, pf_data_q, ptr_data_q;
  wire [1:0][1:0] pf_dest_q;
  wire [1:0][3:0] ptr_num_q;
  wire w13_we_q, mem_wr_en_q;
  wire [WORD_W-1:0] w13_data_q, mem_wr_addr_q, mem_wr_data_q;
  wire [ACC_W-1:0] acc_a, acc_b;
  wire [5:0] flags;
  wire [13:4][WORD_W-1:0] r;
  logic [13:4][WORD_W-1:0] v, e;
  logic [ACC_W-1:0] ex_acc [2];
  logic [1:0] ex_ov, ex_sat;
  int checks = 0;
  int n_mismatch = 0;
  integer seed = 32'h0000_4608;
  int fa [8] = '{4, 4, 4, 4, 5, 5, 6, 4};
  int fb [8] = '{5, 6, 7, 5, 6, 7, 7, 5};

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  dsp_mac_multiply_unit dsp_mac_multiply_unit_i (
    .mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .core_control_register(ccr), .w4(r[4]), .w5(r[5]), .w6(r[6]), .w7(r[7]),
    .w8(r[8]), .w9(r[9]), .w10(r[10]), .w11(r[11]), .w12(r[12]), .w13(r[13]),
    .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .pf_we_q(pf_we_q), .pf_dest_q(pf_dest_q), .pf_data_q(pf_data_q),
    .ptr_we_q(ptr_we_q), .ptr_num_q(ptr_num_q), .ptr_data_q(ptr_data_q),
    .w13_we_q(w13_we_q), .w13_data_q(w13_data_q), .mem_wr_en_q(mem_wr_en_q),
    .mem_wr_addr_q(mem_wr_addr_q), .mem_wr_data_q(mem_wr_data_q),
    .accumulator_a(acc_a), .accumulator_b(acc_b), .sat_clear(sat_clear),
    .acc_a_overflow_flag(flags[0]), .acc_b_overflow_flag(flags[1]),
    .either_acc_overflow_flag(flags[2]), .acc_a_saturation_flag(flags[3]),
    .acc_b_saturation_flag(flags[4]), .either_acc_saturation_flag(flags[5])
  );

  core_model core_model_i (
    .mclk(mclk), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_en_q(mem_wr_en_q), .mem_wr_addr_q(mem_wr_addr_q),
    .mem_wr_data_q(mem_wr_data_q), .pf_we_q(pf_we_q), .pf_dest_q(pf_dest_q),
    .pf_data_q(pf_data_q), .ptr_we_q(ptr_we_q), .ptr_num_q(ptr_num_q),
    .ptr_data_q(ptr_data_q), .w13_we_q(w13_we_q), .w13_data_q(w13_data_q), .r(r)
  );

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  function automatic logic [ACC_W-1:0] prod(input logic [15:0] a, input logic [15:0] b,
      input logic int_m);
    logic [ACC_W-1:0] p;
    p = {{24{a[15]}}, a} * {{24{b[15]}}, b};
    return int_m ? p : p << 1;
  endfunction : prod

  function automatic logic ovf(input logic [ACC_W-1:0] x);
    return !(&x[39:31] || !(|x[39:31]));
  endfunction : ovf

  function automatic logic [15:0] rnd(input logic [ACC_W-1:0] x);
    logic [ACC_W-1:0] t;
    t = x + ROUND_ADD;
    return t[31:16];
  endfunction : rnd

  task automatic pf(input logic [3:0] f, input int base, input logic [1:0] d);
    int pn;
    logic [15:0] ea;
    pn = base + f[3];
    ea = (f == PF_OFFSET) ? v[base + 1] + v[12] : v[pn];
    if (f != PF_NONE) e[4 + d] = core_model_i.peek(ea);
    if (f[2:0] != 3'h0 && f[2:0] != 3'h4) e[pn] = v[pn] + {{12{f[2]}}, f[2:0], 1'h0};
  endtask : pf

  // Op 0 multiply, 1 square, 2 negated, 3 subtract, 4 prefetch-store, 5 undecodable
  task automatic run_one(input int op, input logic corner);
    logic [ACC_W-1:0] p, res, oth;
    logic [INSTR_W-1:0] w;
    logic [3:0] fi, fj;
    logic [1:0] xx, aa, clr;
    logic [2:0] m;
    logic a_sel, int_m, set, mw;
    int fx, fy;
    fi = 4'($random(seed));
    fj = 4'($random(seed));
    xx = 2'($random(seed));
    aa = 2'($random(seed));
    clr = 2'($random(seed)) & 2'($random(seed));
    a_sel = corner ? 1'h0 : 1'($random(seed));
    int_m = corner ? 1'h0 : 1'($random(seed));
    m = 3'($unsigned($random(seed)) % 6);
    if (m > 3'h2) m = m + 3'h1;
    for (int k = 4; k < 14; k++) v[k] = 16'($random(seed));
    if (corner) m = 3'h0;
    if (corner) v[5:4] = {16'h8000, 16'h8000};
    if (op == 1) m = {1'h0, aa};
    if (op == 3 && aa == 2'h3) aa = 2'h2;
    if (op == 2) clr = 2'h0;
    case (op)
      0: w = {OPC_MAC, m, a_sel, 1'h0, xx, xx + 2'h1, fi, fj, AA_MULT};
      1: w = {OPC_SQR, m[1:0], a_sel, 1'h0, xx, xx + 2'h1, fi, fj, AA_SQR};
      2: w = {OPC_MAC, m, a_sel, 1'h1, xx, xx + 2'h1, fi, fj, AA_MULT};
      3: w = {OPC_MAC, m, a_sel, 1'h1, xx, xx + 2'h1, fi, fj, aa};
      4: w = {OPC_MAC, M_PFST, a_sel, 1'h0, xx, xx + 2'h1, fi, fj, aa};
      // Refused forms: unused pair code, or prefetch-store with the subtract bit
      default: w = {OPC_MAC, aa[0] ? M_UNUSED : M_PFST, a_sel, !aa[0], xx, xx + 2'h1, fi, fj,
          AA_MULT};
    endcase
    e = v;
    fx = (op == 1) ? 4 + m[1:0] : fa[m];
    fy = (op == 1) ? fx : fb[m];
    p = prod(v[fx], v[fy], int_m);
    case (op)
      0, 1: res = p;
      2: res = -p;
      default: res = ex_acc[a_sel] - p;
    endcase
    set = op == 3 && ex_acc[a_sel][39] != p[39] && res[39] != ex_acc[a_sel][39];
    oth = ex_acc[!a_sel];
    if (op < 4) ex_acc[a_sel] = res;
    if (op < 4) ex_ov[a_sel] = ovf(res);
    for (int k = 0; k < 2; k++) ex_sat[k] = (set && a_sel == k) || (ex_sat[k] && !clr[k]);
    if (op < 5) pf(fi, 8, xx);
    if (op < 5) pf(fj, 10, xx + 2'h1);
    mw = (op == 3 || op == 4) && aa == WB_MEM;
    if ((op == 3 || op == 4) && aa == WB_REG) e[13] = rnd(oth);
    if (mw) e[13] = v[13] + WB_STEP;
    @(posedge mclk);
    instr <= w;
    instr_valid <= 1'h1;
    ccr <= {15'h0000, int_m};
    sat_clear <= clr;
    core_model_i.r <= v;
    @(posedge mclk);
    instr_valid <= 1'h0;
    sat_clear <= 2'h0;
    #1;
    check(acc_a, ex_acc[0]);
    check(acc_b, ex_acc[1]);
    check(40'(flags), 40'({|ex_sat, ex_sat, |ex_ov, ex_ov}));
    @(posedge mclk);
    #1;
    for (int k = 4; k < 14; k++) check(40'(r[k]), 40'(e[k]));
    if (mw) check(40'(core_model_i.peek(v[13])), 40'(rnd(oth)));
  endtask : run_one

  initial begin
    rst = 1'h1;
    instr_valid = 1'h0;
    instr = 24'h00_0000;
    ccr = 16'h0000;
    sat_clear = 2'h0;
    ex_acc = '{ACC_RST, ACC_RST};
    ex_ov = 2'h0;
    ex_sat = 2'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    #1;
    check(acc_a, ACC_RST);
    check(40'(flags), 40'h00_0000_0000);
    // Fractional full-scale multiply of W4 by W5 into A, then drive A to overflow by subtraction
    run_one(0, 1'h1);
    repeat (260) run_one(3, 1'h1);
    for (int k = 0; k < 420; k++) run_one(k % 6, 1'h0);
    summarize();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule : testbench

`default_nettype wire
